// *** include/pms_pkg.sv ***
// Constants and types for the PHY mode, autoneg expansion and crossover register bank.
// Assumes a management station clocking frames over a serial management link.
package pms_pkg;
    // Register indices on the management link
    localparam logic [4:0] REG_AN_EXP = 5'h06;
    localparam logic [4:0] REG_MODE_CTRL = 5'h11;
    localparam logic [4:0] REG_SPEC_MODES = 5'h12;
    localparam logic [4:0] REG_SPEC_CTRL = 5'h1B;
    // Expansion status bit positions
    localparam int EXP_PDF = 4;
    localparam int EXP_LP_NP = 3;
    localparam int EXP_NP = 2;
    localparam int EXP_PAGE = 1;
    localparam int EXP_LP_AN = 0;
    // Mode control bit positions
    localparam int MC_EDPD = 13;
    localparam int MC_ENERGY = 1;
    // Special modes fields
    localparam int SM_MODE_HI = 7;
    localparam int SM_MODE_LO = 5;
    localparam int SM_ADDR_HI = 4;
    localparam logic [15:0] SM_RESET = 16'h00E1;
    // Special control bit positions
    localparam int SC_OVR = 15;
    localparam int SC_AMDIX = 14;
    localparam int SC_XSTATE = 13;
    localparam int SC_PLL = 10;
    localparam int SC_RX_POL = 4;
    // Operating modes
    localparam logic [2:0] MODE_10HD = 3'h0;
    localparam logic [2:0] MODE_10FD = 3'h1;
    localparam logic [2:0] MODE_100HD = 3'h2;
    localparam logic [2:0] MODE_100FD = 3'h3;
    localparam logic [2:0] MODE_AN100HD = 3'h4;
    localparam logic [2:0] MODE_REPEATER = 3'h5;
    localparam logic [2:0] MODE_ALL = 3'h7;
    // Local next page capability
    localparam logic NEXT_PAGE_ABLE = 1'h0;
    // Frame layout
    localparam logic [5:0] PRE_BITS = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0B;
    localparam logic [5:0] TA_LAST = 6'h01;
    localparam logic [5:0] DATA_LAST = 6'h0F;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    // Energy timeout
    localparam int ENERGY_MS = 256;
    localparam int CLK_KHZ = 200000;
    localparam int unsigned ENERGY_CYC = ENERGY_MS * CLK_KHZ;
    // Frame receiver states
    typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA} pms_state_t;
    // Line status from the autoneg and receive logic
    typedef struct packed {
        logic parallel_fault_evt;
        logic page_rx_evt;
        logic lp_next_page_able;
        logic lp_autoneg_able;
        logic energy_seen;
        logic rx_polarity_reversed;
        logic neg_speed100;
        logic neg_full_duplex;
    } pms_line_t;
    // Decoded configuration for the PHY core
    typedef struct packed {
        logic energy_detect_powerdown_en;
        logic autoneg_en;
        logic [3:0] ctrl_bits;
        logic [3:0] adv_bits;
        logic crs_on_tx;
        logic repeater_mode;
        logic auto_xover_en;
        logic pair_swap;
        logic rx_pll_ref_lock;
    } pms_cfg_t;
endpackage

// *** logic/pms_regs.sv ***
// Management register bank: autoneg expansion, mode control, special modes, special control.
// Assumes mdc and mdio_i synchronous to clk; soft_rst is a one-cycle pulse from the core.
// Summary of operation
// R1: Parallel detection fault latches high in expansion bit 4 until read.
// R2: New page received latches high in expansion bit 1, else reads 0.
// R3: Expansion bit 2 reports local next page ability, reading 0.
// R4: Expansion bits 3 and 0 report partner next page and autoneg ability.
// R5: Mode control bit 13 enables energy-detect power-down, default 0.
// R6: Energy flag drops after 256ms without energy, reads 1 with energy.
// R7: Hardware reset sets the energy flag; software reset leaves it.
// R8: Special modes bits 7:5 select operating mode, default 111.
// R9: Special modes bits 4:0 hold the management address, default 00001.
// R10: Modes 000-011 disable autoneg and force speed and duplex bits.
// R11: Forced 100 half asserts carrier on transmit and receive; full receive only.
// R12: Mode 100 autonegotiates advertising 100 half only, control 1100, adv 0100.
// R13: Mode 101 is repeater: autoneg, 100 half advertised, carrier on receive.
// R14: Station never programs reserved mode 110.
// R15: Mode 111 advertises everything; speed and duplex follow negotiation.
// R16: Override bit 15 chooses between strap pin and register crossover control.
// R17: Under override, bit 14 enables auto crossover; station keeps bit 13 zero then.
// R18: Override with auto off: bit 13 swaps transmit and receive pairs.
// R19: Station never writes override, auto and manual state all set.
// R20: Bit 10 holds the 10M receive PLL on the reference clock.
// R21: Special control bit 4 reports reversed 10M receive polarity.
// R22: Mode, address and PLL lock survive software reset.
// R23: Latched-high bits hold until read, then clear unless condition persists.
`timescale 1ns/100ps
module pms_regs #(
    parameter int unsigned ENERGY_CYCLES = pms_pkg::ENERGY_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    // Management link
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n,
    // Line status and strap
    input wire pms_pkg::pms_line_t line,
    input wire logic crossover_strap_pin,
    // Configuration to the PHY core
    output pms_pkg::pms_cfg_t cfg,
    output logic [4:0] mgmt_port_address
);
    pms_pkg::pms_state_t state_q;
    logic mdc_q;
    logic mdc_rise;
    logic [5:0] cnt_q;
    logic [15:0] sh_q;
    logic [11:0] hdr;
    logic [4:0] reg_q;
    logic rd_q;
    logic rd_start;
    logic wr_stb;
    logic [15:0] wr_data;
    logic [15:0] rd_sh_q;
    logic [15:0] rd_mux;
    logic clr_exp;
    logic pdf_q;
    logic page_q;
    logic edpd_q;
    logic energy_present_flag_q;
    logic [31:0] quiet_q;
    logic [15:0] smodes_q;
    logic ovr_q;
    logic amdix_q;
    logic xstate_q;
    logic rx_pll_ref_lock_q;
    logic [2:0] mode;
    pms_pkg::pms_cfg_t cfg_d;
    pms_pkg::pms_cfg_t cfg_q;

    // Edge of the management clock and frame fields
    assign mdc_rise = mdc & ~mdc_q;
    assign hdr = {sh_q[10:0], mdio_i};
    assign mode = smodes_q[pms_pkg::SM_MODE_HI:pms_pkg::SM_MODE_LO];
    assign mgmt_port_address = smodes_q[pms_pkg::SM_ADDR_HI:0];
    assign rd_start = mdc_rise && state_q == pms_pkg::S_HDR && cnt_q == pms_pkg::HDR_LAST
        && hdr[9:5] == mgmt_port_address && hdr[11:10] == pms_pkg::OP_READ; // R9
    assign wr_stb = mdc_rise && state_q == pms_pkg::S_DATA && cnt_q == pms_pkg::DATA_LAST && !rd_q;
    assign wr_data = {sh_q[14:0], mdio_i};
    assign clr_exp = rd_start && hdr[4:0] == pms_pkg::REG_AN_EXP; // R23

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mdc_q <= 1'h0;
        end else begin
            mdc_q <= mdc;
        end
    end

    // Frame receiver: preamble, start, header, turnaround, data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= pms_pkg::S_PRE;
            cnt_q <= 6'h00;
            sh_q <= 16'h0000;
            reg_q <= 5'h00;
            rd_q <= 1'h0;
        end else if (mdc_rise) begin
            sh_q <= {sh_q[14:0], mdio_i};
            case (state_q)
                pms_pkg::S_PRE: begin
                    if (mdio_i) begin
                        cnt_q <= (cnt_q == pms_pkg::PRE_BITS) ? cnt_q : cnt_q + 6'h01;
                    end else begin
                        if (cnt_q == pms_pkg::PRE_BITS) begin
                            state_q <= pms_pkg::S_ST;
                        end
                        cnt_q <= 6'h00;
                    end
                end
                pms_pkg::S_ST: begin
                    state_q <= mdio_i ? pms_pkg::S_HDR : pms_pkg::S_PRE;
                    cnt_q <= 6'h00;
                end
                pms_pkg::S_HDR: begin
                    if (cnt_q == pms_pkg::HDR_LAST) begin
                        cnt_q <= 6'h00;
                        reg_q <= hdr[4:0];
                        rd_q <= hdr[11:10] == pms_pkg::OP_READ;
                        if (hdr[9:5] == mgmt_port_address && (hdr[11:10] == pms_pkg::OP_READ
                            || hdr[11:10] == pms_pkg::OP_WRITE)) begin // R9
                            state_q <= pms_pkg::S_TA;
                        end else begin
                            state_q <= pms_pkg::S_PRE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                pms_pkg::S_TA: begin
                    if (cnt_q == pms_pkg::TA_LAST) begin
                        state_q <= pms_pkg::S_DATA;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                pms_pkg::S_DATA: begin
                    if (cnt_q == pms_pkg::DATA_LAST) begin
                        state_q <= pms_pkg::S_PRE;
                        cnt_q <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                default: begin
                    state_q <= pms_pkg::S_PRE;
                    cnt_q <= 6'h00;
                end
            endcase
        end
    end

    // Read data selection, unused bits read as zero
    always_comb begin
        rd_mux = 16'h0000;
        case (hdr[4:0])
            pms_pkg::REG_AN_EXP: begin
                rd_mux[pms_pkg::EXP_PDF] = pdf_q; // R1
                rd_mux[pms_pkg::EXP_LP_NP] = line.lp_next_page_able; // R4
                rd_mux[pms_pkg::EXP_NP] = pms_pkg::NEXT_PAGE_ABLE; // R3
                rd_mux[pms_pkg::EXP_PAGE] = page_q; // R2
                rd_mux[pms_pkg::EXP_LP_AN] = line.lp_autoneg_able; // R4
            end
            pms_pkg::REG_MODE_CTRL: begin
                rd_mux[pms_pkg::MC_EDPD] = edpd_q;
                rd_mux[pms_pkg::MC_ENERGY] = energy_present_flag_q;
            end
            pms_pkg::REG_SPEC_MODES: begin
                rd_mux = smodes_q;
            end
            pms_pkg::REG_SPEC_CTRL: begin
                rd_mux[pms_pkg::SC_OVR] = ovr_q;
                rd_mux[pms_pkg::SC_AMDIX] = amdix_q;
                rd_mux[pms_pkg::SC_XSTATE] = xstate_q;
                rd_mux[pms_pkg::SC_PLL] = rx_pll_ref_lock_q;
                rd_mux[pms_pkg::SC_RX_POL] = line.rx_polarity_reversed; // R21
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    // Read driver: zero in second turnaround bit, then data MSB first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_sh_q <= 16'h0000;
            mdio_o <= 1'h0;
            mdio_oe_n <= 1'h1;
        end else if (rd_start) begin
            rd_sh_q <= rd_mux;
        end else if (mdc_rise && rd_q && state_q == pms_pkg::S_TA) begin
            mdio_oe_n <= 1'h0;
            if (cnt_q == pms_pkg::TA_LAST) begin
                mdio_o <= rd_sh_q[15];
                rd_sh_q <= {rd_sh_q[14:0], 1'h0};
            end else begin
                mdio_o <= 1'h0;
            end
        end else if (mdc_rise && rd_q && state_q == pms_pkg::S_DATA) begin
            if (cnt_q == pms_pkg::DATA_LAST) begin
                mdio_oe_n <= 1'h1;
                mdio_o <= 1'h0;
            end else begin
                mdio_o <= rd_sh_q[15];
                rd_sh_q <= {rd_sh_q[14:0], 1'h0};
            end
        end
    end

    // Latched-high expansion bits, a new event beats the read clear
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            pdf_q <= 1'h0;
            page_q <= 1'h0;
        end else begin
            pdf_q <= line.parallel_fault_evt | (pdf_q & ~clr_exp); // R1 R23
            page_q <= line.page_rx_evt | (page_q & ~clr_exp); // R2 R23
        end
    end

    // Energy-detect power-down enable
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            edpd_q <= 1'h0;
        end else if (wr_stb && reg_q == pms_pkg::REG_MODE_CTRL) begin
            edpd_q <= wr_data[pms_pkg::MC_EDPD]; // R5
        end
    end

    // Energy present flag with quiet-line timeout, untouched by soft reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            energy_present_flag_q <= 1'h1; // R7
            quiet_q <= 32'h00000000;
        end else if (line.energy_seen) begin
            energy_present_flag_q <= 1'h1; // R6
            quiet_q <= 32'h00000000;
        end else if (quiet_q == 32'(ENERGY_CYCLES - 1)) begin
            energy_present_flag_q <= 1'h0; // R6
        end else begin
            quiet_q <= quiet_q + 32'h00000001;
        end
    end

    // Special modes: reloaded only by hardware reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            smodes_q <= pms_pkg::SM_RESET; // R8 R9
        end else if (wr_stb && reg_q == pms_pkg::REG_SPEC_MODES) begin
            smodes_q <= wr_data; // R22
        end
    end

    // Crossover controls, cleared by either reset
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst) begin
            ovr_q <= 1'h0;
            amdix_q <= 1'h0;
            xstate_q <= 1'h0;
        end else if (wr_stb && reg_q == pms_pkg::REG_SPEC_CTRL) begin
            ovr_q <= wr_data[pms_pkg::SC_OVR];
            amdix_q <= wr_data[pms_pkg::SC_AMDIX];
            xstate_q <= wr_data[pms_pkg::SC_XSTATE];
        end
    end

    // Receive PLL hold, survives soft reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_pll_ref_lock_q <= 1'h0;
        end else if (wr_stb && reg_q == pms_pkg::REG_SPEC_CTRL) begin
            rx_pll_ref_lock_q <= wr_data[pms_pkg::SC_PLL]; // R20 R22
        end
    end

    // Mode decode into control and advertisement bits [13,12,10,8] and [8,7,6,5]
    always_comb begin
        cfg_d = '0;
        cfg_d.energy_detect_powerdown_en = edpd_q; // R5
        cfg_d.rx_pll_ref_lock = rx_pll_ref_lock_q; // R20
        cfg_d.auto_xover_en = ovr_q ? amdix_q : crossover_strap_pin; // R16 R17
        cfg_d.pair_swap = ovr_q && !amdix_q && xstate_q; // R18
        case (mode)
            pms_pkg::MODE_10HD: begin
                cfg_d.ctrl_bits = 4'h0; // R10
                cfg_d.crs_on_tx = 1'h1;
            end
            pms_pkg::MODE_10FD: begin
                cfg_d.ctrl_bits = 4'h1; // R10
            end
            pms_pkg::MODE_100HD: begin
                cfg_d.ctrl_bits = 4'h8; // R10
                cfg_d.crs_on_tx = 1'h1; // R11
            end
            pms_pkg::MODE_100FD: begin
                cfg_d.ctrl_bits = 4'h9; // R10 R11
            end
            pms_pkg::MODE_AN100HD: begin
                cfg_d.autoneg_en = 1'h1;
                cfg_d.ctrl_bits = 4'hC; // R12
                cfg_d.adv_bits = 4'h4;
                cfg_d.crs_on_tx = 1'h1;
            end
            pms_pkg::MODE_REPEATER: begin
                cfg_d.autoneg_en = 1'h1;
                cfg_d.ctrl_bits = 4'hC; // R13
                cfg_d.adv_bits = 4'h4;
                cfg_d.repeater_mode = 1'h1;
            end
            pms_pkg::MODE_ALL: begin
                cfg_d.autoneg_en = 1'h1;
                cfg_d.ctrl_bits = {line.neg_speed100, 2'h2, line.neg_full_duplex}; // R15
                cfg_d.adv_bits = 4'hF;
                cfg_d.crs_on_tx = !line.neg_full_duplex;
            end
            default: begin
                cfg_d.ctrl_bits = 4'h0; // Reserved mode, station keeps clear of it
            end
        endcase
    end

    // Registered configuration outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end
    assign cfg = cfg_q;

    // Checks
    a_pdf_latch: assert property (@(posedge clk) disable iff (!rst_n)
        line.parallel_fault_evt && !soft_rst |=> pdf_q) // R1
        else $error("parallel fault not latched");
    a_page_hold: assert property (@(posedge clk) disable iff (!rst_n)
        page_q && !clr_exp && !soft_rst |=> page_q) // R2
        else $error("page bit lost before read");
    a_edpd_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_stb && reg_q == pms_pkg::REG_MODE_CTRL && !soft_rst
        |=> edpd_q == $past(wr_data[pms_pkg::MC_EDPD])) // R5
        else $error("power-down enable not written");
    a_energy_drop: assert property (@(posedge clk) disable iff (!rst_n)
        quiet_q == 32'(ENERGY_CYCLES - 1) && !line.energy_seen |=> !energy_present_flag_q) // R6
        else $error("energy flag did not drop");
    a_energy_soft: assert property (@(posedge clk) disable iff (!rst_n)
        soft_rst && !line.energy_seen && quiet_q != 32'(ENERGY_CYCLES - 1)
        |=> $stable(energy_present_flag_q)) // R7
        else $error("soft reset touched energy flag");
    a_modes_keep: assert property (@(posedge clk) disable iff (!rst_n)
        soft_rst && !wr_stb |=> $stable(smodes_q) && $stable(rx_pll_ref_lock_q)) // R22
        else $error("soft reset changed kept fields");
    a_forced_noan: assert property (@(posedge clk) disable iff (!rst_n)
        !mode[2] |=> !cfg.autoneg_en && cfg.adv_bits == 4'h0) // R10
        else $error("forced mode left autoneg on");
    a_strap_select: assert property (@(posedge clk) disable iff (!rst_n)
        !ovr_q && $past(rst_n) |=> cfg.auto_xover_en == $past(crossover_strap_pin) && !cfg.pair_swap) // R16
        else $error("strap not followed");
    a_swap_manual: assert property (@(posedge clk) disable iff (!rst_n)
        ovr_q && !amdix_q |=> cfg.pair_swap == $past(xstate_q) && !cfg.auto_xover_en) // R18
        else $error("manual pair mapping wrong");
    a_repeater_crs: assert property (@(posedge clk) disable iff (!rst_n)
        mode == pms_pkg::MODE_REPEATER |=> cfg.repeater_mode && !cfg.crs_on_tx
        && cfg.ctrl_bits == 4'hC) // R13
        else $error("repeater decode wrong");
    a_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clr_exp && !line.page_rx_evt && !soft_rst |=> !page_q && rd_sh_q[pms_pkg::EXP_PAGE] == $past(page_q)) // R23
        else $error("latched bit not cleared by read");
endmodule

// *** verification/pms_mgmt_station.sv ***
// Management station model: clocks whole frames onto the serial management link.
// Assumes the bank samples mdc with clk; the data line has a pull-up when nobody drives.
`timescale 1ns/100ps
module pms_mgmt_station (
    // Clock
    input wire logic clk,
    // Management link
    output logic mdc,
    output logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_n
);
    logic drv = 1'h1;
    logic drv_en = 1'h0;
    initial mdc = 1'h0;

    // Resolved line: device, station, or pull-up
    assign mdio_i = !mdio_oe_n ? mdio_o : (drv_en ? drv : 1'h1);

    // One frame, mdc low two clocks then high three; read bits sampled just before each rise
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
        rd = 16'h0;
        // Reserved mode value is never sent
        if (op == pms_pkg::OP_WRITE && ra == pms_pkg::REG_SPEC_MODES && wd[7:5] == 3'h6) begin
            return;
        end
        // Manual state kept clear while automatic crossover is chosen
        if (op == pms_pkg::OP_WRITE && ra == pms_pkg::REG_SPEC_CTRL && wd[15] && wd[14]) begin
            bits[13] = 1'h0;
        end
        for (int i = 63; i >= 0; i--) begin
            @(posedge clk);
            mdc <= 1'h0;
            drv <= bits[i];
            drv_en <= !(op == pms_pkg::OP_READ && i <= 17);
            repeat (2) @(posedge clk);
            if (i <= 15) begin
                rd[i] = mdio_i;
            end
            mdc <= 1'h1;
            repeat (2) @(posedge clk);
        end
        // Link clock stands low between frames
        mdc <= 1'h0;
        drv_en <= 1'h0;
        @(posedge clk);
    endtask
endmodule

// *** verification/phy_mode_autoneg_status_regs_tb_top.sv ***
// Self-checking bench for the mode, autoneg expansion and crossover register bank.
// Assumes the station model in the same folder and a shortened energy timeout.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module phy_mode_autoneg_status_regs_tb_top;
    localparam int unsigned QUIET = 400;
    localparam logic [31:0] CTRL_T = 32'h00CC9810;
    localparam logic [7:0] CRS_T = 8'h15;
    localparam logic [4:0] REGS [5] = '{pms_pkg::REG_AN_EXP, pms_pkg::REG_MODE_CTRL,
        pms_pkg::REG_SPEC_MODES, pms_pkg::REG_SPEC_CTRL, 5'h07};
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic soft_rst = 1'h0;
    logic mdc, mdio_i, mdio_o, mdio_oe_n;
    logic crossover_strap_pin = 1'h0;
    pms_pkg::pms_line_t line = 8'h08;
    pms_pkg::pms_cfg_t cfg;
    logic [4:0] mgmt_port_address;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    // Behavioural model state
    logic pdf_l, page_l, edpd, energy, ovr, amdix, xst, pll;
    logic [2:0] mode;
    logic [4:0] addr;
    logic [7:0] sm_hi;

    pms_regs #(.ENERGY_CYCLES(QUIET)) u_pms_regs (.clk(clk), .rst_n(rst_n), .soft_rst(soft_rst),
        .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .line(line),
        .crossover_strap_pin(crossover_strap_pin), .cfg(cfg), .mgmt_port_address(mgmt_port_address));
    pms_mgmt_station u_pms_mgmt_station (.clk(clk), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n));

    // Clock generation
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Model values after hardware reset
    task automatic model_reset;
        {pdf_l, page_l, edpd, ovr, amdix, xst, pll} = 7'h00;
        energy = 1'h1;
        {sm_hi, mode, addr} = 16'h00E1;
    endtask

    function automatic logic [15:0] model_rd(input logic [4:0] ra);
        case (ra)
            pms_pkg::REG_AN_EXP: return {11'h0, pdf_l, line.lp_next_page_able, 1'h0, page_l, line.lp_autoneg_able};
            pms_pkg::REG_MODE_CTRL: return {2'h0, edpd, 11'h0, energy, 1'h0};
            pms_pkg::REG_SPEC_MODES: return {sm_hi, mode, addr};
            pms_pkg::REG_SPEC_CTRL: return {ovr, amdix, xst, 2'h0, pll, 5'h0, line.rx_polarity_reversed, 4'h0};
            default: return 16'h0;
        endcase
    endfunction

    // Read and compare; a read of the expansion register clears latched bits
    task automatic rd_chk(input logic [4:0] ra);
        logic [15:0] d;
        u_pms_mgmt_station.frame(pms_pkg::OP_READ, addr, ra, 16'h0, d);
        `CHK(d, model_rd(ra))
        if (ra == pms_pkg::REG_AN_EXP) begin
            {pdf_l, page_l} = 2'h0;
        end
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] d;
        u_pms_mgmt_station.frame(pms_pkg::OP_WRITE, addr, ra, wd, d);
        case (ra)
            pms_pkg::REG_MODE_CTRL: edpd = wd[13];
            pms_pkg::REG_SPEC_MODES: {sm_hi, mode, addr} = wd;
            pms_pkg::REG_SPEC_CTRL: {ovr, amdix, xst, pll} = {wd[15:13], wd[10]};
            default: ;
        endcase
        repeat (3) @(posedge clk);
    endtask

    // Expected decoded configuration; forced modes advertise nothing
    task automatic cfg_chk;
        pms_pkg::pms_cfg_t e;
        pms_pkg::pms_cfg_t g;
        g = cfg;
        e = '0;
        e.energy_detect_powerdown_en = edpd;
        e.autoneg_en = mode[2] && mode != 3'h6;
        e.ctrl_bits = (mode == 3'h7) ? {line.neg_speed100, 2'h2, line.neg_full_duplex} : CTRL_T[mode * 4 +: 4];
        e.adv_bits = (mode == 3'h7) ? 4'hF : (mode[2] && !mode[1]) ? 4'h4 : 4'h0;
        e.crs_on_tx = (mode == 3'h7) ? !line.neg_full_duplex : CRS_T[mode];
        e.repeater_mode = (mode == 3'h5);
        e.auto_xover_en = ovr ? amdix : crossover_strap_pin;
        e.pair_swap = ovr && !amdix && xst;
        e.rx_pll_ref_lock = pll;
        `CHK(g, e)
    endtask

    // Main sequence
    initial begin
        logic [15:0] d;
        void'($urandom(43));
        model_reset();
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        `CHK(mgmt_port_address, 5'h01)
        cfg_chk();
        for (int r = 0; r < 5; r++) begin
            rd_chk(REGS[r]);
        end
        // Partner abilities, polarity and negotiated result at random
        line[5:4] <= 2'($urandom);
        line[2:0] <= 3'($urandom);
        @(posedge clk);
        rd_chk(pms_pkg::REG_AN_EXP);
        rd_chk(pms_pkg::REG_SPEC_CTRL);
        // One-cycle events latch until read
        line.parallel_fault_evt <= 1'h1;
        @(posedge clk);
        line.parallel_fault_evt <= 1'h0;
        line.page_rx_evt <= 1'h1;
        @(posedge clk);
        line.page_rx_evt <= 1'h0;
        {pdf_l, page_l} = 2'h3;
        repeat (4) @(posedge clk);
        rd_chk(pms_pkg::REG_AN_EXP);
        rd_chk(pms_pkg::REG_AN_EXP);
        // Every operating mode except the reserved one
        for (int m = 0; m < 8; m++) begin
            if (m != 6) begin
                wr(pms_pkg::REG_SPEC_MODES, {8'($urandom), 3'(m), 5'h01});
                rd_chk(pms_pkg::REG_SPEC_MODES);
                cfg_chk();
            end
        end
        // New address: frames to the old one are ignored
        wr(pms_pkg::REG_SPEC_MODES, 16'h00EA);
        `CHK(mgmt_port_address, 5'h0A)
        u_pms_mgmt_station.frame(pms_pkg::OP_READ, 5'h01, pms_pkg::REG_SPEC_MODES, 16'h0, d);
        `CHK(d, 16'hFFFF)
        rd_chk(pms_pkg::REG_SPEC_MODES);
        // Crossover override, auto, manual state, PLL lock and strap
        for (int i = 0; i < 16; i++) begin
            if (i[2:0] != 3'h7) begin
                crossover_strap_pin <= i[3];
                wr(pms_pkg::REG_SPEC_CTRL, {i[2:0], 2'h0, i[0], 10'h0});
                rd_chk(pms_pkg::REG_SPEC_CTRL);
                cfg_chk();
            end
        end
        // Power-down enable and energy timeout
        wr(pms_pkg::REG_MODE_CTRL, 16'h2000);
        cfg_chk();
        line.energy_seen <= 1'h0;
        rd_chk(pms_pkg::REG_MODE_CTRL);
        repeat (QUIET) @(posedge clk);
        energy = 1'h0;
        rd_chk(pms_pkg::REG_MODE_CTRL);
        // Software reset keeps mode, address, PLL lock and energy flag
        wr(pms_pkg::REG_SPEC_CTRL, 16'hC400);
        soft_rst <= 1'h1;
        @(posedge clk);
        soft_rst <= 1'h0;
        {edpd, ovr, amdix, xst} = 4'h0;
        repeat (3) @(posedge clk);
        for (int r = 0; r < 4; r++) begin
            rd_chk(REGS[r]);
        end
        cfg_chk();
        // Hardware reset restores defaults and forces the energy flag
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        model_reset();
        repeat (3) @(posedge clk);
        // Soft reset on a quiet line keeps the forced flag; read it before the timeout
        soft_rst <= 1'h1;
        @(posedge clk);
        soft_rst <= 1'h0;
        @(posedge clk);
        rd_chk(pms_pkg::REG_MODE_CTRL);
        line.energy_seen <= 1'h1;
        for (int r = 0; r < 4; r++) begin
            rd_chk(REGS[r]);
        end
        tally_and_finish();
    end
endmodule
